// File: rtl/spg_defs.vh
// Offsets, field positions, reset values and timing counts for the switch/PWM/pin block
`ifndef SPG_DEFS_VH
`define SPG_DEFS_VH
`define SPG_ADDR_SWITCH_B   7'h15
`define SPG_ADDR_PIN_CFG    7'h17
`define SPG_ADDR_PWM_A      7'h18
`define SPG_ADDR_PWM_B      7'h19
`define SPG_ADDR_RATE       7'h1c
`define SPG_ADDR_SCRATCH    7'h1e
`define SPG_RST_BYTE        8'h00
`define SPG_SWITCH_B_MASK   8'h77
`define SPG_RATE_MASK       8'h05
`define SPG_SEL_OFF         3'h0
`define SPG_SEL_ON          3'h1
`define SPG_SEL_TIMER_A     3'h2
`define SPG_SEL_TIMER_B     3'h3
`define SPG_SEL_PWM_A       3'h4
`define SPG_SEL_PWM_B       3'h5
`define SPG_PIN_OFF         3'h4
`define SPG_PIN_WAKE        3'h5
`define SPG_PIN_LOW_SIDE    3'h6
`define SPG_PIN_HIGH_SIDE   3'h7
`define SPG_RATE_A_BIT      0
`define SPG_RATE_B_BIT      2
`define SPG_CLK_HZ          10000000
`define SPG_PWM_SLOW_HZ     200
`define SPG_PWM_FAST_HZ     400
`define SPG_PWM_STEPS       255
`define SPG_WAKE_FILTER_US  16
`define SPG_WAKE_FILTER_CYC ((`SPG_WAKE_FILTER_US * `SPG_CLK_HZ + 999999) / 1000000)
`define SPG_TICK_SLOW_CYC   (`SPG_CLK_HZ / (`SPG_PWM_SLOW_HZ * `SPG_PWM_STEPS))
`define SPG_TICK_FAST_CYC   (`SPG_CLK_HZ / (`SPG_PWM_FAST_HZ * `SPG_PWM_STEPS))
`endif

// File: rtl/spg_switch_pwm_gpio.v
// Switch source selection, pin functions, two PWM generators and a scratch byte
//
// Summary of operation
// - Selector codes 000 off, 001 on, 010 first timer, 011 second timer.
// - Code 100 first PWM, 101 second PWM; 110 and 111 reserved.
// - Overcurrent or overtemperature on a switch clears its selector to off.
// - Reserved bits ignore writes and read as zero.
// - Fixed-output duty field: 20%, 10%, 5%, 2.5%.
// - Second pin codes 000 to 011 carry the second fixed output.
// - First pin codes 000 to 011 carry the first fixed output.
// - Pin code 100 off, 101 wake input with 16 us filter.
// - Pin code 110 low-side switch on, 111 high-side switch on.
// - Duty 0 fully off, 255 fully on, else value over 255.
// - Very short duty pulses may not appear; duty one unrealizable.
// - Rate bit 0 selects 200 Hz, 1 selects 400 Hz per channel.
// - Restart keeps rate bits, clears selectors; power-on, soft reset clear all.
// - Pin and duty registers clear on power-on or soft reset, keep on restart.
// - Scratch byte cleared only at power-on, kept through soft reset.
// - Scratch accessible only in normal mode, unused inside, kept on restart.
// - Timer-driven switch follows the timer output, which starts once configured.
`timescale 1ns/1ps
`include "spg_defs.vh"
module spg_switch_pwm_gpio #(
  parameter integer WAKE_CYC  = `SPG_WAKE_FILTER_CYC,
  parameter integer SLOW_CYC  = `SPG_TICK_SLOW_CYC,
  parameter integer FAST_CYC  = `SPG_TICK_FAST_CYC
) (
  input  wire       i_sys_clk,
  input  wire       i_rst,
  input  wire       i_soft_rst,
  input  wire       i_restart,
  input  wire       i_normal_mode,
  input  wire [6:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  input  wire       i_third_fault,
  input  wire       i_fourth_fault,
  input  wire       i_first_timer,
  input  wire       i_second_timer,
  input  wire       i_fixed_out_first,
  input  wire       i_pin_a_wake,
  input  wire       i_pin_b_wake,
  output reg        o_third_switch,
  output reg        o_fourth_switch,
  output reg        o_pin_a_out,
  output reg        o_pin_a_oe,
  output reg        o_pin_a_low_side,
  output reg        o_pin_b_out,
  output reg        o_pin_b_oe,
  output reg        o_pin_b_low_side,
  output reg        o_pin_a_wake_evt,
  output reg        o_pin_b_wake_evt,
  output reg        o_pwm_a,
  output reg        o_pwm_b
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [7:0] switch_b_ff;
  reg  [7:0] pin_cfg_ff;
  reg  [7:0] duty_a_ff;
  reg  [7:0] duty_b_ff;
  reg  [7:0] rate_ff;
  reg  [7:0] scratch_ff;
  reg  [7:0] nxt_switch_b;

  wire wr_sw  = i_wr && (i_addr == `SPG_ADDR_SWITCH_B);
  wire wr_pin = i_wr && (i_addr == `SPG_ADDR_PIN_CFG);
  wire wr_pa  = i_wr && (i_addr == `SPG_ADDR_PWM_A);
  wire wr_pb  = i_wr && (i_addr == `SPG_ADDR_PWM_B);
  wire wr_rt  = i_wr && (i_addr == `SPG_ADDR_RATE);
  wire wr_sc  = i_wr && (i_addr == `SPG_ADDR_SCRATCH) && i_normal_mode;

  // Fault clear beats a write in the same cycle so a faulted switch never re-arms
  always @* begin
    nxt_switch_b = switch_b_ff;
    if (wr_sw) begin
      nxt_switch_b = i_wdata & `SPG_SWITCH_B_MASK;
    end
    if (i_third_fault) begin
      nxt_switch_b[2:0] = `SPG_SEL_OFF;
    end
    if (i_fourth_fault) begin
      nxt_switch_b[6:4] = `SPG_SEL_OFF;
    end
  end

  // Scratch ignores soft reset and restart; only power-on clears it
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      scratch_ff       <= `SPG_RST_BYTE;
    end else if (wr_sc) begin
      scratch_ff       <= i_wdata;
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_rst || i_soft_rst) begin
      switch_b_ff <= `SPG_RST_BYTE;
      pin_cfg_ff  <= `SPG_RST_BYTE;
      duty_a_ff   <= `SPG_RST_BYTE;
      duty_b_ff   <= `SPG_RST_BYTE;
      rate_ff     <= `SPG_RST_BYTE;
    end else if (i_restart) begin
      switch_b_ff <= `SPG_RST_BYTE;
      rate_ff     <= rate_ff & `SPG_RATE_MASK;
    end else begin
      switch_b_ff <= nxt_switch_b;
      if (wr_pin) begin
        pin_cfg_ff <= i_wdata;
      end
      if (wr_pa) begin
        duty_a_ff <= i_wdata;
      end
      if (wr_pb) begin
        duty_b_ff <= i_wdata;
      end
      if (wr_rt) begin
        rate_ff <= i_wdata & `SPG_RATE_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      if (i_addr == `SPG_ADDR_SWITCH_B) begin
        o_rdata <= switch_b_ff;
      end else if (i_addr == `SPG_ADDR_PIN_CFG) begin
        o_rdata <= pin_cfg_ff;
      end else if (i_addr == `SPG_ADDR_PWM_A) begin
        o_rdata <= duty_a_ff;
      end else if (i_addr == `SPG_ADDR_PWM_B) begin
        o_rdata <= duty_b_ff;
      end else if (i_addr == `SPG_ADDR_RATE) begin
        o_rdata <= rate_ff;
      end else if (i_addr == `SPG_ADDR_SCRATCH && i_normal_mode) begin
        o_rdata <= scratch_ff;
      end else begin
        o_rdata <= 8'h00;
      end
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // PWM generators
  // ----------------------------------------------------------------
  reg [15:0] pre_a_ff;
  reg [15:0] pre_b_ff;
  reg [7:0]  phase_a_ff;
  reg [7:0]  phase_b_ff;
  reg [7:0]  act_a_ff;
  reg [7:0]  act_b_ff;

  function [15:0] tick_len;
    input fast;
    begin
      tick_len = fast ? FAST_CYC[15:0] : SLOW_CYC[15:0];
    end
  endfunction

  // Duty 255 compares above every phase 0..254, giving a solid high
  function pwm_level;
    input [7:0] duty;
    input [7:0] phase;
    begin
      pwm_level = (phase < duty);
    end
  endfunction

  // Rate bit is read every cycle; a change stretches or shortens the current step
  wire tick_a = (pre_a_ff >= tick_len(rate_ff[`SPG_RATE_A_BIT]) - 16'h0001);
  wire tick_b = (pre_b_ff >= tick_len(rate_ff[`SPG_RATE_B_BIT]) - 16'h0001);
  wire wrap_a = tick_a && (phase_a_ff == 8'hfe);
  wire wrap_b = tick_b && (phase_b_ff == 8'hfe);

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      pre_a_ff   <= 16'h0000;
      pre_b_ff   <= 16'h0000;
      phase_a_ff <= 8'h00;
      phase_b_ff <= 8'h00;
      act_a_ff   <= 8'h00;
      act_b_ff   <= 8'h00;
      o_pwm_a    <= 1'b0;
      o_pwm_b    <= 1'b0;
    end else begin
      pre_a_ff <= tick_a ? 16'h0000 : pre_a_ff + 16'h0001;
      pre_b_ff <= tick_b ? 16'h0000 : pre_b_ff + 16'h0001;
      if (tick_a) begin
        phase_a_ff <= wrap_a ? 8'h00 : phase_a_ff + 8'h01;
      end
      if (tick_b) begin
        phase_b_ff <= wrap_b ? 8'h00 : phase_b_ff + 8'h01;
      end
      if (wrap_a) begin
        act_a_ff <= duty_a_ff;
      end
      if (wrap_b) begin
        act_b_ff <= duty_b_ff;
      end
      o_pwm_a <= pwm_level(act_a_ff, phase_a_ff);
      o_pwm_b <= pwm_level(act_b_ff, phase_b_ff);
    end
  end

  // ----------------------------------------------------------------
  // Switch source multiplexers
  // ----------------------------------------------------------------
  function src_pick;
    input [2:0] sel;
    input       t1;
    input       t2;
    input       p1;
    input       p2;
    begin
      case (sel)
        `SPG_SEL_ON:      src_pick = 1'b1;
        `SPG_SEL_TIMER_A: src_pick = t1;
        `SPG_SEL_TIMER_B: src_pick = t2;
        `SPG_SEL_PWM_A:   src_pick = p1;
        `SPG_SEL_PWM_B:   src_pick = p2;
        default:          src_pick = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin input synchronisers and wake filters
  // ----------------------------------------------------------------
  reg [1:0]  wa_sync_ff;
  reg [1:0]  wb_sync_ff;
  reg [1:0]  t_sync_ff;
  reg [1:0]  t2_sync_ff;
  reg [1:0]  fo_sync_ff;
  reg        wa_stable_ff;
  reg        wb_stable_ff;
  reg [7:0]  wa_cnt_ff;
  reg [7:0]  wb_cnt_ff;
  reg [4:0]  fo2_cnt_ff;
  reg [15:0] fo2_pre_ff;

  wire wake_en_a = (pin_cfg_ff[2:0] == `SPG_PIN_WAKE);
  wire wake_en_b = (pin_cfg_ff[5:3] == `SPG_PIN_WAKE);

  // Second fixed output is derived internally: a 20-step cycle off the slow tick
  // Lowest setting keeps only the first half of step zero
  reg fo2_level;
  always @* begin
    case (pin_cfg_ff[7:6])
      2'h0:    fo2_level = (fo2_cnt_ff < 5'd4);
      2'h1:    fo2_level = (fo2_cnt_ff < 5'd2);
      2'h2:    fo2_level = (fo2_cnt_ff < 5'd1);
      default: fo2_level = (fo2_cnt_ff < 5'd1) && (fo2_pre_ff < SLOW_CYC[15:0] / 16'h0002);
    endcase
  end

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      wa_sync_ff   <= 2'h0;
      wb_sync_ff   <= 2'h0;
      t_sync_ff    <= 2'h0;
      t2_sync_ff   <= 2'h0;
      fo_sync_ff   <= 2'h0;
      wa_stable_ff <= 1'b0;
      wb_stable_ff <= 1'b0;
      wa_cnt_ff    <= 8'h00;
      wb_cnt_ff    <= 8'h00;
      fo2_cnt_ff   <= 5'h00;
      fo2_pre_ff   <= 16'h0000;
      o_pin_a_wake_evt <= 1'b0;
      o_pin_b_wake_evt <= 1'b0;
    end else begin
      wa_sync_ff <= {wa_sync_ff[0], i_pin_a_wake};
      wb_sync_ff <= {wb_sync_ff[0], i_pin_b_wake};
      t_sync_ff  <= {t_sync_ff[0], i_first_timer};
      t2_sync_ff <= {t2_sync_ff[0], i_second_timer};
      fo_sync_ff <= {fo_sync_ff[0], i_fixed_out_first};
      fo2_pre_ff <= (fo2_pre_ff >= SLOW_CYC[15:0] - 16'h0001) ? 16'h0000 : fo2_pre_ff + 16'h0001;
      if (fo2_pre_ff >= SLOW_CYC[15:0] - 16'h0001) begin
        fo2_cnt_ff <= (fo2_cnt_ff == 5'd19) ? 5'h00 : fo2_cnt_ff + 5'h01;
      end
      o_pin_a_wake_evt <= 1'b0;
      o_pin_b_wake_evt <= 1'b0;
      // Static filter: level must hold for the full window before it is accepted
      if (!wake_en_a || wa_sync_ff[1] == wa_stable_ff) begin
        wa_cnt_ff <= 8'h00;
      end else if (wa_cnt_ff >= WAKE_CYC[7:0] - 8'h01) begin
        wa_cnt_ff        <= 8'h00;
        wa_stable_ff     <= wa_sync_ff[1];
        o_pin_a_wake_evt <= 1'b1;
      end else begin
        wa_cnt_ff <= wa_cnt_ff + 8'h01;
      end
      if (!wake_en_b || wb_sync_ff[1] == wb_stable_ff) begin
        wb_cnt_ff <= 8'h00;
      end else if (wb_cnt_ff >= WAKE_CYC[7:0] - 8'h01) begin
        wb_cnt_ff        <= 8'h00;
        wb_stable_ff     <= wb_sync_ff[1];
        o_pin_b_wake_evt <= 1'b1;
      end else begin
        wb_cnt_ff <= wb_cnt_ff + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_third_switch   <= 1'b0;
      o_fourth_switch  <= 1'b0;
      o_pin_a_out      <= 1'b0;
      o_pin_a_oe       <= 1'b0;
      o_pin_a_low_side <= 1'b0;
      o_pin_b_out      <= 1'b0;
      o_pin_b_oe       <= 1'b0;
      o_pin_b_low_side <= 1'b0;
    end else begin
      o_third_switch  <= src_pick(switch_b_ff[2:0], t_sync_ff[1], t2_sync_ff[1], o_pwm_a, o_pwm_b);
      o_fourth_switch <= src_pick(switch_b_ff[6:4], t_sync_ff[1], t2_sync_ff[1], o_pwm_a, o_pwm_b);
      o_pin_a_out      <= !pin_cfg_ff[2] ? fo_sync_ff[1] : (pin_cfg_ff[2:0] == `SPG_PIN_HIGH_SIDE);
      o_pin_a_oe       <= !pin_cfg_ff[2] || pin_cfg_ff[2:1] == 2'h3;
      o_pin_a_low_side <= (pin_cfg_ff[2:0] == `SPG_PIN_LOW_SIDE);
      o_pin_b_out      <= !pin_cfg_ff[5] ? fo2_level : (pin_cfg_ff[5:3] == `SPG_PIN_HIGH_SIDE);
      o_pin_b_oe       <= !pin_cfg_ff[5] || pin_cfg_ff[5:4] == 2'h3;
      o_pin_b_low_side <= (pin_cfg_ff[5:3] == `SPG_PIN_LOW_SIDE);
    end
  end
endmodule

// File: tb/spg_load_model.sv
// Load model: what a switch or pin sees from outside the block
`timescale 1ns/1ps
module spg_load_model (
  input  wire i_oe,
  input  wire i_out,
  input  wire i_ext,
  output wire o_level
);
  // Driven pin reads back its own level, released pin shows the outside source
  assign o_level = i_oe ? i_out : i_ext;
endmodule

// File: tb/spg_checker.sv
// Port assertions for the switch, PWM and pin configuration block
`timescale 1ns/1ps
module spg_checker (
  input wire       i_sys_clk,
  input wire       i_rst,
  input wire       i_normal_mode,
  input wire [6:0] i_addr,
  input wire [7:0] i_wdata,
  input wire       i_wr,
  input wire       i_rd,
  input wire [7:0] o_rdata,
  input wire       i_third_fault,
  input wire       i_fourth_fault,
  input wire       o_third_switch,
  input wire       o_fourth_switch,
  input wire       o_pin_a_oe,
  input wire       o_pin_a_low_side,
  input wire       o_pin_b_oe,
  input wire       o_pin_b_low_side,
  input wire       o_pin_a_wake_evt
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  property p_rate_zero;
    $past(i_rd && i_addr == 7'h1c) |-> {o_rdata[7:3], o_rdata[1]} == 6'h00;
  endproperty
  a_rate_zero: assert property (p_rate_zero) else $error("rate reserved bits set");
  property p_sel_zero;
    $past(i_rd && i_addr == 7'h15) |-> !o_rdata[7] && !o_rdata[3];
  endproperty
  a_sel_zero: assert property (p_sel_zero) else $error("selector reserved bits set");
  property p_fault3;
    i_third_fault |-> ##2 !o_third_switch;
  endproperty
  a_fault3: assert property (p_fault3) else $error("third switch on after fault");
  property p_fault4;
    i_fourth_fault |-> ##2 !o_fourth_switch;
  endproperty
  a_fault4: assert property (p_fault4) else $error("fourth switch on after fault");
  property p_scratch;
    $past(i_rd && i_addr == 7'h1e && !i_normal_mode) |-> o_rdata == 8'h00;
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch readable outside normal");
  property p_low_a;
    o_pin_a_low_side |-> o_pin_a_oe;
  endproperty
  a_low_a: assert property (p_low_a) else $error("pin a low side not driven");
  property p_low_b;
    o_pin_b_low_side |-> o_pin_b_oe;
  endproperty
  a_low_b: assert property (p_low_b) else $error("pin b low side not driven");
  property p_wake;
    o_pin_a_wake_evt |=> !o_pin_a_wake_evt;
  endproperty
  a_wake: assert property (p_wake) else $error("wake event longer than one cycle");
  property p_duty;
    $past(i_wr && i_addr == 7'h18, 3) && !$past(i_wr, 2) && $past(i_rd && i_addr == 7'h18)
      |-> o_rdata == $past(i_wdata, 3);
  endproperty
  a_duty: assert property (p_duty) else $error("duty readback differs");
endmodule
bind spg_switch_pwm_gpio spg_checker CHK (.i_sys_clk, .i_rst, .i_normal_mode, .i_addr, .i_wdata, .i_wr,
  .i_rd, .o_rdata, .i_third_fault, .i_fourth_fault, .o_third_switch, .o_fourth_switch, .o_pin_a_oe,
  .o_pin_a_low_side, .o_pin_b_oe, .o_pin_b_low_side, .o_pin_a_wake_evt);

// File: tb/spg_switch_pwm_gpio_tb.sv
// Self-checking bench for the switch, PWM and pin configuration block
`timescale 1ns/1ps
module spg_switch_pwm_gpio_tb;
  localparam int SLOW = 4;
  localparam int FAST = 2;
  localparam int PER = 255 * SLOW;
  logic i_sys_clk = 1'h0, i_rst = 1'h1, i_soft_rst = 1'h0, i_restart = 1'h0, i_normal_mode = 1'h1;
  logic [6:0] i_addr = 7'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'h0, i_rd = 1'h0, i_third_fault = 1'h0, i_fourth_fault = 1'h0, ext_a = 1'h0;
  logic i_first_timer = 1'h0, i_second_timer = 1'h0, i_fixed_out_first = 1'h0, ext_b = 1'h0;
  wire [7:0] o_rdata;
  wire i_pin_a_wake, i_pin_b_wake, o_third_switch, o_fourth_switch, o_pin_a_out, o_pin_a_oe, o_pin_a_low_side;
  wire o_pin_b_out, o_pin_b_oe, o_pin_b_low_side, o_pin_a_wake_evt, o_pin_b_wake_evt, o_pwm_a, o_pwm_b;
  int n_mismatch = 0, checked = 0, n_wake = 0, n_wake_b = 0, k;
  spg_switch_pwm_gpio #(.WAKE_CYC(8), .SLOW_CYC(SLOW), .FAST_CYC(FAST)) DUT (.i_sys_clk, .i_rst, .i_soft_rst,
    .i_restart, .i_normal_mode, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_third_fault, .i_fourth_fault,
    .i_first_timer, .i_second_timer, .i_fixed_out_first, .i_pin_a_wake, .i_pin_b_wake, .o_third_switch,
    .o_fourth_switch, .o_pin_a_out, .o_pin_a_oe, .o_pin_a_low_side, .o_pin_b_out, .o_pin_b_oe,
    .o_pin_b_low_side, .o_pin_a_wake_evt, .o_pin_b_wake_evt, .o_pwm_a, .o_pwm_b);
  spg_load_model LA (.i_oe(o_pin_a_oe), .i_out(o_pin_a_out), .i_ext(ext_a), .o_level(i_pin_a_wake));
  spg_load_model LB (.i_oe(o_pin_b_oe), .i_out(o_pin_b_out), .i_ext(ext_b), .o_level(i_pin_b_wake));
  initial begin
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) n_wake <= n_wake + o_pin_a_wake_evt;
  always @(posedge i_sys_clk) n_wake_b <= n_wake_b + o_pin_b_wake_evt;
  // ---------------------------------------------------------------
  // Bus and compare helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, exp, input string nm);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'h1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'h0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_rd <= 1'h1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'h0;
    @(negedge i_sys_clk);
    chk(o_rdata, e, $sformatf("reg %h", a));
  endtask
  // Counts high cycles of one PWM output over one period starting at a rising edge
  task automatic hcount(input logic b, input int n, output int h);
    h = 0;
    for (int i = 0; i < n && (b ? o_pwm_b : o_pwm_a) !== 1'h0; i++) @(negedge i_sys_clk);
    for (int i = 0; i < n && (b ? o_pwm_b : o_pwm_a) !== 1'h1; i++) @(negedge i_sys_clk);
    for (int i = 0; i < n; i++) begin
      h += ((b ? o_pwm_b : o_pwm_a) === 1'h1);
      @(negedge i_sys_clk);
    end
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    logic [6:0] al [6] = '{7'h15, 7'h17, 7'h18, 7'h19, 7'h1c, 7'h1e};
    foreach (al[i]) rd(al[i], 8'h00);
    wr(7'h15, 8'hff);
    rd(7'h15, 8'h77);
    wr(7'h1c, 8'hff);
    rd(7'h1c, 8'h05);
    wr(7'h00, 8'hff);
    rd(7'h00, 8'h00);
    wr(7'h18, 8'h5a);
    rd(7'h18, 8'h5a);
    wr(7'h1c, 8'h00);
  endtask
  task automatic t_switch;
    logic [7:0] ex [2] = '{8'h16, 8'h2a};
    for (int p = 0; p < 2; p++) begin
      @(posedge i_sys_clk);
      i_first_timer <= (p == 0);
      i_second_timer <= (p == 1);
      wr(7'h18, p ? 8'h00 : 8'hff);
      wr(7'h19, p ? 8'hff : 8'h00);
      cyc(2 * PER);
      for (int c = 0; c < 8; c++) begin
        wr(7'h15, {1'h0, c[2:0], 1'h0, c[2:0]});
        cyc(3);
        chk(o_third_switch, ex[p][c], "third");
        chk(o_fourth_switch, ex[p][c], "fourth");
      end
    end
  endtask
  task automatic t_fault;
    wr(7'h15, 8'h11);
    @(posedge i_sys_clk);
    i_third_fault <= 1'h1;
    @(posedge i_sys_clk);
    i_third_fault <= 1'h0;
    rd(7'h15, 8'h10);
    @(posedge i_sys_clk);
    i_fourth_fault <= 1'h1;
    @(posedge i_sys_clk);
    i_fourth_fault <= 1'h0;
    rd(7'h15, 8'h00);
  endtask
  task automatic t_pwm;
    wr(7'h18, 8'h80);
    wr(7'h19, 8'h40);
    wr(7'h1c, 8'h04);
    cyc(2 * PER);
    hcount(1'h0, PER, k);
    chk(k, 16'(128 * SLOW), "pwm a");
    hcount(1'h1, PER / 2, k);
    chk(k, 16'(64 * FAST), "pwm b");
    wr(7'h18, 8'h00);
    cyc(2 * PER);
    hcount(1'h0, PER, k);
    chk(k, 16'h0000, "pwm a off");
  endtask
  task automatic t_pins;
    logic [7:0] oe_e = 8'hcf, lo_e = 8'h40;
    for (int c = 0; c < 8; c++) begin
      wr(7'h17, {2'h0, c[2:0], c[2:0]});
      cyc(4);
      chk(o_pin_a_oe, oe_e[c], "oe a");
      chk(o_pin_b_oe, oe_e[c], "oe b");
      chk(o_pin_a_low_side, lo_e[c], "low a");
      chk(o_pin_b_low_side, lo_e[c], "low b");
      if (c >= 4) begin
        chk(o_pin_a_out, c == 7, "out a");
        chk(o_pin_b_out, c == 7, "out b");
      end
      if (c == 0) begin
        @(posedge i_sys_clk);
        i_fixed_out_first <= 1'h1;
        cyc(6);
        chk(o_pin_a_out, 1'h1, "fixed out a");
      end
    end
  endtask
  // One period of the second fixed output is 20 slow ticks
  task automatic t_fixed;
    logic [7:0] hi_e [4] = '{8'(4 * SLOW), 8'(2 * SLOW), 8'(SLOW), 8'(SLOW / 2)};
    for (int d = 0; d < 4; d++) begin
      wr(7'h17, {d[1:0], 3'h0, 3'h4});
      cyc(4);
      k = 0;
      repeat (20 * SLOW) begin
        k += (o_pin_b_out === 1'h1);
        @(negedge i_sys_clk);
      end
      chk(k, hi_e[d], "fixed out duty");
    end
  endtask
  task automatic t_wake;
    int w, wb;
    wr(7'h15, 8'h02);
    wr(7'h17, 8'h2d);
    cyc(20);
    w = n_wake;
    wb = n_wake_b;
    @(posedge i_sys_clk);
    ext_a <= 1'h1;
    ext_b <= 1'h1;
    cyc(4);
    @(posedge i_sys_clk);
    ext_a <= 1'h0;
    ext_b <= 1'h0;
    cyc(30);
    chk(n_wake - w, 16'h0000, "short glitch");
    chk(n_wake_b - wb, 16'h0000, "short glitch b");
    @(posedge i_sys_clk);
    ext_a <= 1'h1;
    ext_b <= 1'h1;
    cyc(30);
    chk(n_wake - w, 16'h0001, "wake");
    chk(n_wake_b - wb, 16'h0001, "wake b");
  endtask
  task automatic t_modes;
    wr(7'h17, 8'h2d);
    wr(7'h18, 8'h33);
    wr(7'h1c, 8'h05);
    wr(7'h1e, 8'ha5);
    @(posedge i_sys_clk);
    i_restart <= 1'h1;
    @(posedge i_sys_clk);
    i_restart <= 1'h0;
    rd(7'h17, 8'h2d);
    rd(7'h18, 8'h33);
    rd(7'h1c, 8'h05);
    rd(7'h1e, 8'ha5);
    @(posedge i_sys_clk);
    i_soft_rst <= 1'h1;
    @(posedge i_sys_clk);
    i_soft_rst <= 1'h0;
    rd(7'h17, 8'h00);
    rd(7'h1c, 8'h00);
    rd(7'h1e, 8'ha5);
    @(posedge i_sys_clk);
    i_normal_mode <= 1'h0;
    wr(7'h1e, 8'h5a);
    rd(7'h1e, 8'h00);
    @(posedge i_sys_clk);
    i_normal_mode <= 1'h1;
    rd(7'h1e, 8'ha5);
    @(posedge i_sys_clk);
    i_rst <= 1'h1;
    cyc(2);
    @(posedge i_sys_clk);
    i_rst <= 1'h0;
    rd(7'h1e, 8'h00);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_rst <= 1'h0;
    t_regs;
    t_switch;
    t_fault;
    t_pwm;
    t_pins;
    t_fixed;
    t_wake;
    t_modes;
    finish_test;
  end
  initial begin
    repeat (60000) @(posedge i_sys_clk);
    n_mismatch++;
    finish_test;
  end
endmodule
